/* File: hw/itm_pkg.sv */
// shared constants and types for instruction timing and decode
package itm_pkg;
  // opcodes
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_ALT_NOP   = 8'hA5;
  localparam logic [7:0] OP_LJMP      = 8'h02;
  localparam logic [7:0] OP_LCALL     = 8'h12;
  localparam logic [7:0] OP_JBC       = 8'h10;
  localparam logic [7:0] OP_JB        = 8'h20;
  localparam logic [7:0] OP_JNB       = 8'h30;
  localparam logic [7:0] OP_JC        = 8'h40;
  localparam logic [7:0] OP_JNC       = 8'h50;
  localparam logic [7:0] OP_JZ        = 8'h60;
  localparam logic [7:0] OP_JNZ       = 8'h70;
  localparam logic [7:0] OP_JMP_IND   = 8'h73;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP      = 8'h80;
  localparam logic [7:0] OP_CODE_PC   = 8'h83;
  localparam logic [7:0] OP_CODE_DP   = 8'h93;
  localparam logic [7:0] OP_ORL_NBIT  = 8'hA0;
  localparam logic [7:0] OP_ANL_NBIT  = 8'hB0;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_AIMM = 8'hB4;
  localparam logic [7:0] OP_COMPARE_JUMP_UNEQUAL_ADIR = 8'hB5;
  localparam logic [7:0] OP_PUSH      = 8'hC0;
  localparam logic [7:0] OP_POP       = 8'hD0;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO_DIR  = 8'hD5;
  localparam logic [7:0] OP_XMOV_RDDP = 8'hE0;
  localparam logic [7:0] OP_XMOV_WRDP = 8'hF0;
  // opcode groups by upper bits; page groups by low five bits, indirect form by bits 3:1
  localparam logic [4:0] PAGE_JMP_LOW  = 5'h01;
  localparam logic [4:0] PAGE_CALL_LOW = 5'h11;
  localparam logic [6:0] COMPARE_JUMP_UNEQUAL_IND_HI   = 7'h5B;
  localparam logic [4:0] COMPARE_JUMP_UNEQUAL_REG_HI   = 5'h17;
  localparam logic [4:0] DECREMENT_JUMP_NONZERO_REG_HI   = 5'h1B;
  localparam logic [6:0] NIBBLE_EXCHANGE_HI       = 7'h6B;
  localparam logic [6:0] XMOV_RDRI_HI  = 7'h71;
  localparam logic [6:0] XMOV_WRRI_HI  = 7'h79;
  localparam logic [2:0] IND_FORM      = 3'h3;
  // lengths in bytes
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // cycle counts
  localparam logic [2:0] CYC_NOP        = 3'h1;
  localparam logic [2:0] CYC_XMOVE      = 3'h3;
  localparam logic [2:0] CYC_CODE       = 3'h3;
  localparam logic [2:0] CYC_SHORT_COND = 3'h2;
  localparam logic [2:0] CYC_BIT_COND   = 3'h3;
  localparam logic [2:0] CYC_COMPARE_JUMP_UNEQUAL       = 3'h3;
  localparam logic [2:0] CYC_COMPARE_JUMP_UNEQUAL_IND   = 3'h4;
  localparam logic [2:0] CYC_SHORT_RELATIVE_JUMP       = 3'h3;
  localparam logic [2:0] CYC_JMP_IND    = 3'h3;
  localparam logic [2:0] CYC_DECREMENT_JUMP_NONZERO_REG   = 3'h2;
  localparam logic [2:0] CYC_DECREMENT_JUMP_NONZERO_DIR   = 3'h3;
  localparam logic [2:0] CYC_NIBBLE_EXCHANGE       = 3'h2;
  localparam logic [2:0] CYC_STACK      = 3'h2;
  localparam logic [2:0] CYC_CARRY      = 3'h2;
  localparam logic [2:0] CYC_PAGE       = 3'h3;
  localparam logic [2:0] CYC_LONG       = 3'h4;
  // address map
  localparam logic [7:0]  GPR_TOP      = 8'h1F;
  localparam logic [7:0]  BIT_BASE     = 8'h20;
  localparam logic [7:0]  BIT_TOP      = 8'h2F;
  localparam logic [7:0]  RAM_LOW_TOP  = 8'h7F;
  localparam logic [15:0] FLASH_TOP    = 16'h1DFF;
  localparam int          EXTERNAL_RAM_BITS    = 9;
  localparam int          BANK_LSB     = 3;
  localparam int          STORE_WE_BIT = 0;
  localparam logic [7:0]  DECREMENT_JUMP_NONZERO_LAST    = 8'h01;

  typedef enum logic [2:0] {REG_BANK, BIT_AREA, LOW_RAM, UPPER_RAM, SPECIAL} itm_region_e;
  typedef enum logic [2:0] {TGT_SEQ, TGT_REL, TGT_PAGE, TGT_IND, TGT_LONG} itm_target_e;
endpackage

/* File: hw/itm_addr_decode.sv */
// address space decoder for data, bit, external and program spaces
`timescale 1ns/1ps
`default_nettype none
module itm_addr_decode #(
  parameter logic [15:0] FLASH_LAST = itm_pkg::FLASH_TOP
)(
  input  wire logic [7:0]                   dataAddr,
  input  wire logic                         indirect,
  input  wire logic [7:0]                   bitAddr,
  input  wire logic [15:0]                  xAddr,
  input  wire logic [15:0]                  progAddr,
  output itm_pkg::itm_region_e              region,
  output logic [7:0]                        bitByte,
  output logic [2:0]                        bitPos,
  output logic [itm_pkg::EXTERNAL_RAM_BITS-1:0]     xramIndex,
  output logic                              progOk
);
  always_comb begin
    if (dataAddr > itm_pkg::RAM_LOW_TOP) begin
      region = indirect ? itm_pkg::UPPER_RAM : itm_pkg::SPECIAL;
    end else if (dataAddr <= itm_pkg::GPR_TOP) begin
      region = itm_pkg::REG_BANK;
    end else if (dataAddr <= itm_pkg::BIT_TOP) begin
      region = itm_pkg::BIT_AREA;
    end else begin
      region = itm_pkg::LOW_RAM;
    end
  end

  // low bit addresses land in the bit area, high ones in aligned special bytes
  always_comb begin
    bitPos = bitAddr[2:0];
    if (bitAddr[7]) begin
      bitByte = {bitAddr[7:3], 3'h0};
    end else begin
      bitByte = itm_pkg::BIT_BASE + {4'h0, bitAddr[6:3]};
    end
  end

  assign xramIndex = xAddr[itm_pkg::EXTERNAL_RAM_BITS-1:0];
  assign progOk    = (progAddr <= FLASH_LAST);
endmodule
`default_nettype wire

/* File: hw/itm_core_timing.sv */
// instruction timing sequencer and operand decode for the core
// Notes on behaviour
// - external data moves: one byte, three cycles
// - code byte read: one byte, three cycles
// - carry and zero jumps: two bytes, 2/3
// - bit jumps 3/4; clear variant clears set bit
// - compare indirect and jump: 4/5 cycles
// - compare with accumulator and jump: 3/4 cycles
// - short relative jump: two bytes, three cycles
// - indirect jump to accumulator plus pointer, 3
// - decrement and jump: 2/3, direct form 3/4
// - nibble exchange swaps low nibbles only, 2
// - push and pop: two bytes, two cycles
// - inverted bit carry logic, source untouched, 2
// - relative target: next address plus signed offset
// - page target keeps page of next address
// - direct below 0x80 RAM, above special space
// - opcode 0xA5 behaves as no operation
// - program flash spans 0x0000 to 0x1DFF
// - store enable redirects external writes to flash
// - 0x00-0x1F are four banks of eight
// - 0x20-0x2F are also 128 bits
// - indirect above 0x7F reaches upper RAM
// - external RAM mirrors every 512 bytes
// - untaken branch finishes one cycle sooner
// - status word bits 4:3 select bank
`timescale 1ns/1ps
`default_nettype none
module itm_core_timing #(
  parameter logic [15:0] FLASH_LAST = itm_pkg::FLASH_TOP
)(
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     instValid,
  output logic                          instReady,
  input  wire logic [15:0]              instAddr,
  input  wire logic [7:0]               opcode,
  input  wire logic [7:0]               operandA,
  input  wire logic [7:0]               operandB,
  input  wire logic [7:0]               accValue,
  input  wire logic [15:0]              dataPointer,
  input  wire logic                     carryFlag,
  input  wire logic                     bitValue,
  input  wire logic [7:0]               srcValue,
  input  wire logic [7:0]               ptrValue,
  input  wire logic [7:0]               statusWord,
  input  wire logic [7:0]               storeCtrl,
  input  wire logic [7:0]               codeData,
  output logic                          instDone,
  output logic [15:0]                   nextPc,
  output logic [2:0]                    cycleCount,
  output logic [1:0]                    instLength,
  output logic                          branchTaken,
  output logic [7:0]                    accResult,
  output logic [7:0]                    ramResult,
  output logic                          carryResult,
  output logic                          bitClear,
  output logic [15:0]                   codeAddr,
  output logic [15:0]                   xAddr,
  output logic                          xWrite,
  output logic                          xToProgram,
  output logic [itm_pkg::EXTERNAL_RAM_BITS-1:0] xramIndex,
  output itm_pkg::itm_region_e          dataRegion,
  output logic [7:0]                    dataAddr,
  output logic [7:0]                    bitByte,
  output logic [2:0]                    bitPos,
  output logic                          progInRange
);
  logic [1:0]  decLen;
  logic [2:0]  decBase;
  logic        decIsCond;
  logic        decCond;
  logic [7:0]  decRel;
  logic        isX;
  logic        isXw;
  logic        isCode;
  logic        isXchd;
  logic        isCarry;
  logic        isJbc;
  logic        accZero;
  logic        acceptGo;
  itm_pkg::itm_target_e decTgt;
  logic [2:0]  cntReg;
  logic [2:0]  cntNext;

  assign accZero   = (accValue == 8'h00);
  // ready in the finishing cycle so a new instruction follows back to back
  assign instReady = (cntReg <= 3'h1);
  // done stands in the last cycle of the instruction
  assign instDone  = (cntReg == 3'h1);
  assign acceptGo  = instValid && instReady;

  // opcode class, length, base cycles and branch condition
  always_comb begin
    decLen    = itm_pkg::LEN_ONE;
    decBase   = itm_pkg::CYC_NOP;
    decIsCond = 1'b0;
    decCond   = 1'b0;
    decTgt    = itm_pkg::TGT_SEQ;
    decRel    = operandA;
    isX       = 1'b0;
    isXw      = 1'b0;
    isCode    = 1'b0;
    isXchd    = 1'b0;
    isCarry   = 1'b0;
    isJbc     = 1'b0;
    case (opcode)
      itm_pkg::OP_JC, itm_pkg::OP_JNC, itm_pkg::OP_JZ, itm_pkg::OP_JNZ: begin
        decLen    = itm_pkg::LEN_TWO;
        decBase   = itm_pkg::CYC_SHORT_COND;
        decIsCond = 1'b1;
        decTgt    = itm_pkg::TGT_REL;
        if (opcode == itm_pkg::OP_JC) begin
          decCond = carryFlag;
        end else if (opcode == itm_pkg::OP_JNC) begin
          decCond = !carryFlag;
        end else if (opcode == itm_pkg::OP_JZ) begin
          decCond = accZero;
        end else begin
          decCond = !accZero;
        end
      end
      itm_pkg::OP_JB, itm_pkg::OP_JNB, itm_pkg::OP_JBC: begin
        decLen    = itm_pkg::LEN_THREE;
        decBase   = itm_pkg::CYC_BIT_COND;
        decIsCond = 1'b1;
        decTgt    = itm_pkg::TGT_REL;
        decRel    = operandB;
        decCond   = (opcode == itm_pkg::OP_JNB) ? !bitValue : bitValue;
        isJbc     = (opcode == itm_pkg::OP_JBC);
      end
      itm_pkg::OP_COMPARE_JUMP_UNEQUAL_AIMM, itm_pkg::OP_COMPARE_JUMP_UNEQUAL_ADIR: begin
        decLen    = itm_pkg::LEN_THREE;
        decBase   = itm_pkg::CYC_COMPARE_JUMP_UNEQUAL;
        decIsCond = 1'b1;
        decTgt    = itm_pkg::TGT_REL;
        decRel    = operandB;
        if (opcode == itm_pkg::OP_COMPARE_JUMP_UNEQUAL_AIMM) begin
          decCond = (accValue != operandA);
        end else begin
          decCond = (accValue != srcValue);
        end
      end
      itm_pkg::OP_SHORT_RELATIVE_JUMP: begin
        decLen  = itm_pkg::LEN_TWO;
        decBase = itm_pkg::CYC_SHORT_RELATIVE_JUMP;
        decTgt  = itm_pkg::TGT_REL;
      end
      itm_pkg::OP_JMP_IND: begin
        decBase = itm_pkg::CYC_JMP_IND;
        decTgt  = itm_pkg::TGT_IND;
      end
      itm_pkg::OP_DECREMENT_JUMP_NONZERO_DIR: begin
        decLen    = itm_pkg::LEN_THREE;
        decBase   = itm_pkg::CYC_DECREMENT_JUMP_NONZERO_DIR;
        decIsCond = 1'b1;
        decTgt    = itm_pkg::TGT_REL;
        decRel    = operandB;
        decCond   = (srcValue != itm_pkg::DECREMENT_JUMP_NONZERO_LAST);
      end
      itm_pkg::OP_LJMP, itm_pkg::OP_LCALL: begin
        decLen  = itm_pkg::LEN_THREE;
        decBase = itm_pkg::CYC_LONG;
        decTgt  = itm_pkg::TGT_LONG;
      end
      itm_pkg::OP_CODE_DP, itm_pkg::OP_CODE_PC: begin
        decBase = itm_pkg::CYC_CODE;
        isCode  = 1'b1;
      end
      itm_pkg::OP_XMOV_RDDP, itm_pkg::OP_XMOV_WRDP: begin
        decBase = itm_pkg::CYC_XMOVE;
        isX     = 1'b1;
        isXw    = (opcode == itm_pkg::OP_XMOV_WRDP);
      end
      itm_pkg::OP_PUSH, itm_pkg::OP_POP: begin
        decLen  = itm_pkg::LEN_TWO;
        decBase = itm_pkg::CYC_STACK;
      end
      itm_pkg::OP_ANL_NBIT, itm_pkg::OP_ORL_NBIT: begin
        decLen  = itm_pkg::LEN_TWO;
        decBase = itm_pkg::CYC_CARRY;
        isCarry = 1'b1;
      end
      default: begin
        if (opcode[4:0] == itm_pkg::PAGE_JMP_LOW || opcode[4:0] == itm_pkg::PAGE_CALL_LOW) begin
          decLen  = itm_pkg::LEN_TWO;
          decBase = itm_pkg::CYC_PAGE;
          decTgt  = itm_pkg::TGT_PAGE;
        end else if (opcode[7:1] == itm_pkg::COMPARE_JUMP_UNEQUAL_IND_HI) begin
          decLen    = itm_pkg::LEN_THREE;
          decBase   = itm_pkg::CYC_COMPARE_JUMP_UNEQUAL_IND;
          decIsCond = 1'b1;
          decTgt    = itm_pkg::TGT_REL;
          decRel    = operandB;
          decCond   = (srcValue != operandA);
        end else if (opcode[7:3] == itm_pkg::COMPARE_JUMP_UNEQUAL_REG_HI) begin
          decLen    = itm_pkg::LEN_THREE;
          decBase   = itm_pkg::CYC_COMPARE_JUMP_UNEQUAL;
          decIsCond = 1'b1;
          decTgt    = itm_pkg::TGT_REL;
          decRel    = operandB;
          decCond   = (srcValue != operandA);
        end else if (opcode[7:3] == itm_pkg::DECREMENT_JUMP_NONZERO_REG_HI) begin
          decLen    = itm_pkg::LEN_TWO;
          decBase   = itm_pkg::CYC_DECREMENT_JUMP_NONZERO_REG;
          decIsCond = 1'b1;
          decTgt    = itm_pkg::TGT_REL;
          decCond   = (srcValue != itm_pkg::DECREMENT_JUMP_NONZERO_LAST);
        end else if (opcode[7:1] == itm_pkg::NIBBLE_EXCHANGE_HI) begin
          decBase = itm_pkg::CYC_NIBBLE_EXCHANGE;
          isXchd  = 1'b1;
        end else if (opcode[7:1] == itm_pkg::XMOV_RDRI_HI
                     || opcode[7:1] == itm_pkg::XMOV_WRRI_HI) begin
          decBase = itm_pkg::CYC_XMOVE;
          isX     = 1'b1;
          isXw    = (opcode[7:1] == itm_pkg::XMOV_WRRI_HI);
        end
      end
    endcase
  end

  // branch targets and operand addresses
  logic [15:0] seqC;
  logic [15:0] tgtC;
  logic [15:0] indC;
  logic        takenC;
  logic        indForm;
  logic [7:0]  daC;
  logic [15:0] xaC;
  logic [1:0]  bank;

  assign bank    = statusWord[itm_pkg::BANK_LSB+1:itm_pkg::BANK_LSB];
  assign indForm = (opcode[3:1] == itm_pkg::IND_FORM);
  assign seqC    = instAddr + {14'h0, decLen};
  assign indC    = dataPointer + {8'h00, accValue};
  assign takenC  = (decTgt != itm_pkg::TGT_SEQ) && (!decIsCond || decCond);
  assign xaC     = opcode[1] ? {8'h00, ptrValue} : dataPointer;

  always_comb begin
    case (decTgt)
      itm_pkg::TGT_REL:  tgtC = seqC + {{8{decRel[7]}}, decRel};
      itm_pkg::TGT_PAGE: tgtC = {seqC[15:11], opcode[7:5], operandA};
      itm_pkg::TGT_IND:  tgtC = indC;
      itm_pkg::TGT_LONG: tgtC = {operandA, operandB};
      default:           tgtC = seqC;
    endcase
    if (opcode[3]) begin
      daC = {3'h0, bank, opcode[2:0]};
    end else if (indForm) begin
      daC = ptrValue;
    end else begin
      daC = operandA;
    end
  end

  itm_pkg::itm_region_e       regionC;
  logic [7:0]                 bitByteC;
  logic [2:0]                 bitPosC;
  logic [itm_pkg::EXTERNAL_RAM_BITS-1:0] xramC;
  logic                       progOkC;

  itm_addr_decode #(.FLASH_LAST(FLASH_LAST)) uDecode (
    .dataAddr  (daC),
    .indirect  (indForm),
    .bitAddr   (operandA),
    .xAddr     (xaC),
    .progAddr  (takenC ? tgtC : seqC),
    .region    (regionC),
    .bitByte   (bitByteC),
    .bitPos    (bitPosC),
    .xramIndex (xramC),
    .progOk    (progOkC)
  );

  // sequencer state
  logic       codeRdReg;
  logic       codeRdNext;

  always_comb begin
    cntNext    = cntReg;
    codeRdNext = codeRdReg;
    if (cntReg != 3'h0) begin
      cntNext  = cntReg - 3'h1;
    end
    if (acceptGo) begin
      cntNext    = decBase + {2'h0, decIsCond && decCond};
      codeRdNext = isCode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cntReg    <= 3'h0;
      codeRdReg <= 1'b0;
    end else begin
      cntReg    <= cntNext;
      codeRdReg <= codeRdNext;
    end
  end

  // result registers loaded at acceptance, code byte loaded in the last cycle
  logic [7:0] accNext;
  logic [7:0] ramNext;
  logic       carryNext;

  always_comb begin
    accNext   = accResult;
    ramNext   = ramResult;
    carryNext = carryResult;
    if (cntReg == 3'h1 && codeRdReg) begin
      accNext = codeData;
    end
    if (acceptGo && isXchd) begin
      accNext = {accValue[7:4], srcValue[3:0]};
      ramNext = {srcValue[7:4], accValue[3:0]};
    end
    if (acceptGo && isCarry) begin
      carryNext = (opcode == itm_pkg::OP_ANL_NBIT) ? (carryFlag & ~bitValue)
                                                  : (carryFlag | ~bitValue);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      accResult   <= 8'h00;
      ramResult   <= 8'h00;
      carryResult <= 1'b0;
      nextPc      <= 16'h0000;
      cycleCount  <= 3'h0;
      instLength  <= 2'h0;
      branchTaken <= 1'b0;
      bitClear    <= 1'b0;
      codeAddr    <= 16'h0000;
      xAddr       <= 16'h0000;
      xWrite      <= 1'b0;
      xToProgram  <= 1'b0;
      xramIndex   <= '0;
      dataRegion  <= itm_pkg::REG_BANK;
      dataAddr    <= 8'h00;
      bitByte     <= 8'h00;
      bitPos      <= 3'h0;
      progInRange <= 1'b1;
    end else begin
      accResult   <= accNext;
      ramResult   <= ramNext;
      carryResult <= carryNext;
      if (acceptGo) begin
        nextPc      <= takenC ? tgtC : seqC;
        cycleCount  <= cntNext;
        instLength  <= decLen;
        branchTaken <= takenC;
        bitClear    <= isJbc && bitValue;
        codeAddr    <= (opcode == itm_pkg::OP_CODE_PC) ? seqC + {8'h00, accValue} : indC;
        xAddr       <= xaC;
        xWrite      <= isXw;
        xToProgram  <= isXw && storeCtrl[itm_pkg::STORE_WE_BIT];
        xramIndex   <= xramC;
        dataRegion  <= regionC;
        dataAddr    <= daC;
        bitByte     <= bitByteC;
        bitPos      <= bitPosC;
        progInRange <= progOkC;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_XMOVE_CYCLES: assert property (acceptGo && isX |=> !instDone [*2] ##1 instDone)
    else $error("external move not done in three cycles");
  AST_CODE_READ: assert property (acceptGo && isCode |=> !instDone ##1 !instDone ##1 instDone ##1 accResult == $past(codeData))
    else $error("code byte read wrong timing or data");
  AST_JZ_TAKEN: assert property (acceptGo && opcode == itm_pkg::OP_JZ && accZero |=> !instDone [*2] ##1 instDone)
    else $error("taken zero jump not three cycles");
  AST_JBC_CLEAR: assert property (acceptGo && opcode == itm_pkg::OP_JBC && bitValue |=> bitClear && branchTaken)
    else $error("set bit not cleared by jump and clear");
  AST_COMPARE_JUMP_UNEQUAL_IND: assert property (acceptGo && opcode[7:1] == itm_pkg::COMPARE_JUMP_UNEQUAL_IND_HI && srcValue != operandA |=> !instDone [*4] ##1 instDone)
    else $error("indirect compare branch not five cycles");
  AST_UNTAKEN_SOONER: assert property (acceptGo && decIsCond && !decCond |=> cycleCount == $past(decBase) && !branchTaken ##[1:4] instDone)
    else $error("untaken branch timing wrong");
  AST_SHORT_RELATIVE_JUMP_TARGET: assert property (acceptGo && opcode == itm_pkg::OP_SHORT_RELATIVE_JUMP |=> nextPc == $past(instAddr) + 16'h2 + {{8{$past(operandA[7])}}, $past(operandA)} ##1 !instDone ##1 instDone)
    else $error("short jump target or timing wrong");
  AST_PAGE_TARGET: assert property (acceptGo && opcode[4:0] == itm_pkg::PAGE_JMP_LOW |=> nextPc == {$past(seqC[15:11]), $past(opcode[7:5]), $past(operandA)})
    else $error("page jump left its page");
  AST_DIRECT_REGION: assert property (acceptGo && opcode == itm_pkg::OP_PUSH |=> (dataRegion == itm_pkg::SPECIAL) == ($past(operandA) > itm_pkg::RAM_LOW_TOP))
    else $error("direct address region wrong");
  AST_ALT_NOP: assert property (acceptGo && opcode == itm_pkg::OP_ALT_NOP |=> instDone && nextPc == $past(instAddr) + 16'h1)
    else $error("0xA5 did not act as no operation");
  AST_FLASH_RANGE: assert property (progInRange == (nextPc <= FLASH_LAST))
    else $error("program range flag wrong");
  AST_STORE_REDIR: assert property (acceptGo && isXw |=> xToProgram == $past(storeCtrl[itm_pkg::STORE_WE_BIT]))
    else $error("external write not steered by store enable");
  AST_BANK_SELECT: assert property (acceptGo && opcode[7:3] == itm_pkg::DECREMENT_JUMP_NONZERO_REG_HI |=> dataAddr == {3'h0, $past(bank), $past(opcode[2:0])} && dataRegion == itm_pkg::REG_BANK)
    else $error("register bank address wrong");
  AST_NIBBLE_EXCHANGE_HIGH: assert property (acceptGo && isXchd |=> accResult[7:4] == $past(accValue[7:4]) && ramResult[3:0] == $past(accValue[3:0]))
    else $error("nibble exchange touched high nibbles");

  COV_TAKEN: cover property (acceptGo && decIsCond && decCond ##1 branchTaken);
  COV_XWRITE_PROG: cover property (acceptGo && isXw && storeCtrl[itm_pkg::STORE_WE_BIT]);
  COV_BACK_TO_BACK: cover property (instDone && acceptGo);
endmodule
`default_nettype wire

/* File: verif/itm_mem_model.sv */
// program flash stand-in feeding code bytes to the core
`timescale 1ns/1ps
`default_nettype none
module itm_mem_model (
  input  wire logic [15:0] codeAddr,
  output logic [7:0]       codeData
);
  // reserved program space reads back erased
  always_comb begin
    if (codeAddr <= itm_pkg::FLASH_TOP) begin
      codeData = codeAddr[7:0] ^ codeAddr[15:8];
    end else begin
      codeData = 8'hFF;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_core_instruction_timing_memory_map.sv */
// testbench for the core timing and decode block
`timescale 1ns/1ps
`default_nettype none
module tb_core_instruction_timing_memory_map;
  logic core_clk, srst, instValid, carryFlag, bitValue, instReady, instDone;
  logic branchTaken, carryResult, bitClear, xWrite, xToProgram, progInRange;
  logic [15:0] instAddr, dataPointer, nextPc, codeAddr, xAddr;
  logic [7:0] opcode, operandA, operandB, accValue, srcValue, ptrValue;
  logic [7:0] statusWord, storeCtrl, codeData, accResult, ramResult, dataAddr, bitByte;
  logic [2:0] cycleCount, bitPos;
  logic [1:0] instLength;
  logic [8:0] xramIndex;
  itm_pkg::itm_region_e dataRegion;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  itm_core_timing u_dut (.*);
  itm_mem_model u_mem (.*);

  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // offer one instruction, count cycles up to its done pulse
  task automatic run(input logic [15:0] pc, input logic [7:0] op, a, b, input logic [3:0] n);
    logic [3:0] k;
    instAddr = pc;
    opcode = op;
    operandA = a;
    operandB = b;
    instValid = 1'h1;
    @(negedge core_clk);
    instValid = 1'h0;
    k = 4'h1;
    while (instDone !== 1'h1 && k < 4'h8) begin
      @(negedge core_clk);
      k++;
    end
    chk(k, n);
  endtask

  task automatic t_cond;
    carryFlag = 1'h1;
    run(16'h0100, itm_pkg::OP_JC, 8'hFE, 8'h00, 4'h3);
    chk(nextPc, 16'h0100);
    carryFlag = 1'h0;
    run(16'h0100, itm_pkg::OP_JC, 8'hFE, 8'h00, 4'h2);
    chk(nextPc, 16'h0102);
    bitValue = 1'h1;
    run(16'h0200, itm_pkg::OP_JBC, 8'h13, 8'h10, 4'h4);
    chk(bitClear, 16'h1);
    chk({bitByte, 5'h0, bitPos}, 16'h2203);
    srcValue = 8'h56;
    run(16'h0300, 8'hB6, 8'h55, 8'h80, 4'h5);
    chk(nextPc, 16'h0283);
    srcValue = 8'h55;
    run(16'h0300, 8'hB6, 8'h55, 8'h80, 4'h4);
    accValue = 8'h10;
    run(16'h0300, itm_pkg::OP_COMPARE_JUMP_UNEQUAL_AIMM, 8'h10, 8'h80, 4'h3);
    run(16'h0100, itm_pkg::OP_SHORT_RELATIVE_JUMP, 8'hFE, 8'h00, 4'h3);
    chk(nextPc, 16'h0100);
    statusWord = 8'h10;
    srcValue = 8'h01;
    run(16'h0100, 8'hDD, 8'h05, 8'h00, 4'h2);
    chk({dataRegion, dataAddr}, {5'h0, itm_pkg::REG_BANK, 8'h15});
    $display("test cond done");
  endtask

  task automatic t_xmem;
    dataPointer = 16'h1234;
    run(16'h0400, itm_pkg::OP_XMOV_RDDP, 8'h00, 8'h00, 4'h3);
    chk(xramIndex, 16'h0034);
    storeCtrl = 8'h01;
    run(16'h0400, itm_pkg::OP_XMOV_WRDP, 8'h00, 8'h00, 4'h3);
    chk({xWrite, xToProgram}, 16'h3);
    storeCtrl = 8'h00;
    ptrValue = 8'hC3;
    run(16'h0400, 8'hF3, 8'h00, 8'h00, 4'h3);
    chk({xToProgram, xAddr[14:0]}, 16'h00C3);
    accValue = 8'h23;
    dataPointer = 16'h1000;
    run(16'h0400, itm_pkg::OP_JMP_IND, 8'h00, 8'h00, 4'h3);
    chk(nextPc, 16'h1023);
    run(16'h0400, itm_pkg::OP_CODE_DP, 8'h00, 8'h00, 4'h3);
    @(negedge core_clk);
    chk(accResult, 16'h0033);
    $display("test xmem done");
  endtask

  task automatic t_misc;
    run(16'h0500, itm_pkg::OP_ALT_NOP, 8'h00, 8'h00, 4'h1);
    chk(nextPc, 16'h0501);
    run(16'h07FE, 8'hA1, 8'h34, 8'h00, 4'h3);
    chk(nextPc, 16'h0D34);
    run(16'h1FFE, 8'hA1, 8'h34, 8'h00, 4'h3);
    chk(progInRange, 16'h0);
    accValue = 8'hAB;
    srcValue = 8'hCD;
    ptrValue = 8'h90;
    run(16'h0500, 8'hD7, 8'h00, 8'h00, 4'h2);
    chk({accResult, ramResult}, 16'hADCB);
    chk({dataRegion, dataAddr}, {5'h0, itm_pkg::UPPER_RAM, 8'h90});
    run(16'h0500, itm_pkg::OP_PUSH, 8'h90, 8'h00, 4'h2);
    chk({dataRegion, dataAddr}, {5'h0, itm_pkg::SPECIAL, 8'h90});
    carryFlag = 1'h1;
    bitValue = 1'h0;
    run(16'h0500, itm_pkg::OP_ANL_NBIT, 8'h13, 8'h00, 4'h2);
    chk(carryResult, 16'h1);
    $display("test misc done");
  endtask

  initial begin
    {srst, instValid, carryFlag, bitValue} = 4'h8;
    {instAddr, dataPointer} = 32'h0;
    {opcode, operandA, operandB, accValue, srcValue} = 40'h0;
    {ptrValue, statusWord, storeCtrl} = 24'h0;
    repeat (10) @(negedge core_clk);
    srst = 1'h0;
    t_cond();
    t_xmem();
    t_misc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
